//--- verilog/bit_alu.sv
/*
 * execution datapath for bit test-and-set, bit xor into carry and compare.
 * assumes the decoder fetches operands and writes back dest_bit_out when
 * bit_write_out pulses; flags live here and are presented to the core.
 */
`timescale 1ns/10ps
module bit_alu (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        arst_n_in,
	// request
	input  wire logic        req_in,
	input  wire logic [1:0]  op_in,
	input  wire logic [1:0]  format_in,
	input  wire logic        wide_in,
	input  wire logic        src_is_areg_in,
	input  wire logic        dest_is_areg_in,
	input  wire logic        src_is_imm_in,
	input  wire logic [3:0]  src_reg_id_in,
	input  wire logic [3:0]  dest_reg_id_in,
	input  wire logic        bit_in,
	input  wire logic [15:0] src_in,
	input  wire logic [15:0] dest_in,
	// results
	output logic [7:0]       flags_out,
	output logic             bit_write_out,
	output logic             dest_bit_out,
	output logic             done_out,
	output logic             illegal_out
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_DONE = 2'b10
	} state_t;
	typedef struct packed {
		state_t     state;
		logic [7:0] flags;
		logic       bit_write;
		logic       dest_bit;
		logic       illegal;
	} regs_t;
	regs_t r_q;
	regs_t r_d;

	logic [15:0] src_ext;
	logic [15:0] dest_ext;
	logic        cmp_wide;
	logic        bad_enc;
	logic        c_ovf;
	logic        c_sign;
	logic        c_zero;
	logic        c_carry;
	logic [15:0] chk_diff;

	// ----------------------------------------
	// operand shaping
	// ----------------------------------------
	always_comb begin
		cmp_wide = wide_in | dest_is_areg_in;
		if (format_in == bit_alu_pkg::FMT_QUICK) begin
			src_ext = {{12{src_in[bit_alu_pkg::QUICK_MSB]}}, src_in[3:0]};
		end else if (!wide_in) begin
			// byte source, address register or not, enters as its low byte
			src_ext = {8'h00, src_in[7:0]};
		end else begin
			src_ext = src_in;
		end
		// byte quick: sign lives inside the byte, zero above it even for an address dest
		if (format_in == bit_alu_pkg::FMT_QUICK && !wide_in) begin
			src_ext[15:8] = 8'h00;
		end
		dest_ext = cmp_wide ? dest_in : {8'h00, dest_in[7:0]};
		// encodings the decoder must never issue; flagged rather than executed
		bad_enc = 1'b0;
		if (!wide_in && src_is_areg_in && dest_is_areg_in) begin
			bad_enc = 1'b1;
		end
		if (format_in == bit_alu_pkg::FMT_SHORT) begin
			if (wide_in || src_is_areg_in) begin
				bad_enc = 1'b1;
			end
			if (!src_is_imm_in && src_reg_id_in == dest_reg_id_in) begin
				bad_enc = 1'b1;
			end
		end
	end

	compare_sub u_cmp (
		.dest_in   (dest_ext),
		.src_in    (src_ext),
		.wide_in   (cmp_wide),
		.ovf_out   (c_ovf),
		.sign_out  (c_sign),
		.zero_out  (c_zero),
		.carry_out (c_carry)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.bit_write = 1'b0;
		case (r_q.state)
			ST_IDLE, ST_DONE: begin
				r_d.state = ST_IDLE;
				if (req_in) begin
					r_d.state   = ST_DONE;
					r_d.illegal = 1'b0;
					case (op_in)
						bit_alu_pkg::OP_BIT_TEST_THEN_SET: begin
							r_d.flags[bit_alu_pkg::FLAG_Z] = ~bit_in;
							r_d.flags[bit_alu_pkg::FLAG_C] = bit_in;
							r_d.dest_bit  = 1'b1;
							r_d.bit_write = 1'b1;
						end
						bit_alu_pkg::OP_BIT_XOR_INTO_CARRY: begin
							r_d.flags[bit_alu_pkg::FLAG_C] =
								r_q.flags[bit_alu_pkg::FLAG_C] ^ bit_in;
						end
						bit_alu_pkg::OP_COMPARE_OP: begin
							if (bad_enc) begin
								r_d.illegal = 1'b1;
							end else begin
								// flags only; no result path exists
								r_d.flags[bit_alu_pkg::FLAG_O] = c_ovf;
								r_d.flags[bit_alu_pkg::FLAG_S] = c_sign;
								r_d.flags[bit_alu_pkg::FLAG_Z] = c_zero;
								r_d.flags[bit_alu_pkg::FLAG_C] = c_carry;
							end
						end
						default: begin
							r_d.state = ST_IDLE;
						end
					endcase
				end
			end
			default: begin
				r_d.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r_q.state     <= ST_IDLE;
			r_q.flags     <= bit_alu_pkg::FLAGS_RESET;
			r_q.bit_write <= 1'b0;
			r_q.dest_bit  <= 1'b0;
			r_q.illegal   <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	assign flags_out     = r_q.flags;
	assign bit_write_out = r_q.bit_write;
	assign dest_bit_out  = r_q.dest_bit;
	assign done_out      = (r_q.state == ST_DONE);
	assign illegal_out   = r_q.illegal;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_tset_flags: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_BIT_TEST_THEN_SET |=>
		flags_out[bit_alu_pkg::FLAG_C] == $past(bit_in) &&
		flags_out[bit_alu_pkg::FLAG_Z] == !$past(bit_in))
		else $error("test-and-set flags wrong");
	a_tset_write: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_BIT_TEST_THEN_SET |=> bit_write_out && dest_bit_out)
		else $error("test-and-set did not write one");
	a_xor_carry: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_BIT_XOR_INTO_CARRY |=>
		flags_out[bit_alu_pkg::FLAG_C] == ($past(flags_out[bit_alu_pkg::FLAG_C]) ^ $past(bit_in)))
		else $error("xor carry wrong");
	a_cmp_nowrite: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP |=> !bit_write_out)
		else $error("compare wrote back");
	a_cmp_zero: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && !bad_enc && wide_in |=>
		flags_out[bit_alu_pkg::FLAG_Z] == ($past(dest_in) == $past(src_ext)))
		else $error("compare zero wrong");
	a_cmp_carry: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && !bad_enc && wide_in |=>
		flags_out[bit_alu_pkg::FLAG_C] == ($past(dest_in) >= $past(src_ext)))
		else $error("compare carry wrong");
	a_byte_areg: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && !wide_in &&
		src_is_areg_in && dest_is_areg_in |=> illegal_out)
		else $error("double address register byte compare accepted");
	a_keep_os: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in != bit_alu_pkg::OP_COMPARE_OP |=>
		$stable(flags_out[bit_alu_pkg::FLAG_S]) && $stable(flags_out[bit_alu_pkg::FLAG_O]))
		else $error("bit op touched sign or overflow");
	a_keep_high: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		$stable(flags_out[7:6]) && $stable(flags_out[4]) && $stable(flags_out[1]))
		else $error("unlisted flag changed");

	// difference formed apart from the subtractor that it checks
	assign chk_diff = dest_ext - src_ext;

	a_cmp_sign_bit: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && !bad_enc |=>
		flags_out[bit_alu_pkg::FLAG_S] ==
		($past(cmp_wide) ? $past(chk_diff[15]) : $past(chk_diff[7])))
		else $error("compare sign wrong");
	a_cmp_ovf_word: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && !bad_enc && cmp_wide |=>
		flags_out[bit_alu_pkg::FLAG_O] == ($past(dest_ext[15] != src_ext[15]) &&
		$past(chk_diff[15] != dest_ext[15])))
		else $error("word compare overflow wrong");
	a_cmp_ovf_byte: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && !bad_enc && !cmp_wide |=>
		flags_out[bit_alu_pkg::FLAG_O] == ($past(dest_ext[7] != src_ext[7]) &&
		$past(chk_diff[7] != dest_ext[7])))
		else $error("byte compare overflow wrong");
	a_byte_zero: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && !bad_enc && !cmp_wide |=>
		flags_out[bit_alu_pkg::FLAG_Z] == ($past(chk_diff[7:0]) == 8'h00))
		else $error("byte compare zero wrong");
	a_areg_zext: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && !wide_in && dest_is_areg_in |->
		cmp_wide && src_ext[15:8] == 8'h00)
		else $error("byte compare to address register not widened");
	a_areg_low: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && !wide_in && src_is_areg_in &&
		format_in != bit_alu_pkg::FMT_QUICK |-> src_ext[7:0] == src_in[7:0])
		else $error("address register source not its low byte");
	a_quick_sext: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && format_in == bit_alu_pkg::FMT_QUICK |->
		src_ext[7:3] == {5{src_in[3]}})
		else $error("quick immediate not sign extended");
	a_short_byte: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && format_in == bit_alu_pkg::FMT_SHORT &&
		wide_in |=> illegal_out)
		else $error("word short compare accepted");
	a_short_same: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && format_in == bit_alu_pkg::FMT_SHORT &&
		!src_is_imm_in && src_reg_id_in == dest_reg_id_in |=> illegal_out)
		else $error("short compare with one register accepted");
	a_refused_flags: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_in && op_in == bit_alu_pkg::OP_COMPARE_OP && bad_enc |=> $stable(flags_out))
		else $error("refused compare changed flags");
endmodule : bit_alu

//--- verilog/bit_alu_pkg.sv
/*
 * constants, encodings and the flag layout shared by the bit test and compare datapath.
 * assumes a decoder that presents one operation per request pulse.
 */
// Operation
// - test-and-set: zero if bit 0, carry if 1
// - test-and-set then writes one into bit
// - bit xor: carry becomes carry xor bit
// - compare subtracts source, never writes back
// - byte compare to address register: sixteen-bit
// - byte compare from address register: low byte
// - no byte compare address register both sides
// - compare overflow on signed range exit
// - compare sign is result top bit
// - compare zero when result is zero
// - compare carry set when no borrow
// - quick immediate sign-extended from four bits
// - short format is byte only, limited operands
// - short format: never same register both sides
package bit_alu_pkg;
	// ----------------------------------------
	// operation codes
	// ----------------------------------------
	localparam logic [1:0] OP_NONE             = 2'h0;
	localparam logic [1:0] OP_BIT_TEST_THEN_SET = 2'h1;
	localparam logic [1:0] OP_BIT_XOR_INTO_CARRY = 2'h2;
	localparam logic [1:0] OP_COMPARE_OP       = 2'h3;
	// ----------------------------------------
	// compare formats
	// ----------------------------------------
	localparam logic [1:0] FMT_GENERIC = 2'h0;
	localparam logic [1:0] FMT_QUICK   = 2'h1;
	localparam logic [1:0] FMT_SHORT   = 2'h2;
	// ----------------------------------------
	// flag positions: u i o b s z d c
	// ----------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_D = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_S = 3;
	localparam int FLAG_B = 4;
	localparam int FLAG_O = 5;
	localparam int FLAG_I = 6;
	localparam int FLAG_U = 7;
	localparam logic [7:0]  FLAGS_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET  = 16'h0000;
	localparam int BYTE_MSB = 7;
	localparam int WORD_MSB = 15;
	localparam int QUICK_MSB = 3;
endpackage : bit_alu_pkg

//--- verilog/compare_sub.sv
/*
 * compare subtractor: forms flags of dest minus src at byte or word width.
 * assumes operands already extended by the caller; purely combinational.
 */
`timescale 1ns/10ps
module compare_sub (
	// operands
	input  wire logic [15:0] dest_in,
	input  wire logic [15:0] src_in,
	input  wire logic        wide_in,
	// flags
	output logic             ovf_out,
	output logic             sign_out,
	output logic             zero_out,
	output logic             carry_out
);
	logic [16:0] diff;
	always_comb begin
		diff = {1'b0, dest_in} - {1'b0, src_in};
		if (wide_in) begin
			ovf_out   = (dest_in[15] ^ src_in[15]) & (dest_in[15] ^ diff[15]);
			sign_out  = diff[15];
			zero_out  = (diff[15:0] == 16'h0000);
			carry_out = ~diff[16];
		end else begin
			ovf_out   = (dest_in[7] ^ src_in[7]) & (dest_in[7] ^ diff[7]);
			sign_out  = diff[7];
			zero_out  = (diff[7:0] == 8'h00);
			carry_out = (dest_in[7:0] >= src_in[7:0]);
		end
	end
endmodule : compare_sub

//--- verif/bit_alu_tb.sv
/*
 * self-checking bench for bit_alu: bit ops and compare, legal and refused.
 * assumes one request pulse per op and results registered on the taking edge, checked at the falling edge after it.
 */
`timescale 1ns/10ps
`define CK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module bit_alu_tb;
	logic        sys_clk_in = 1'b0;
	logic        arst_n_in  = 1'b0;
	logic        req_in = 1'b0, w_in = 1'b0, sa_in = 1'b0, da_in = 1'b0, im_in = 1'b0;
	logic        b_in = 1'b0;
	logic [1:0]  op_in = 2'h0, fmt_in = 2'h0;
	logic [3:0]  si_in = 4'h0, di_in = 4'h0;
	logic [15:0] s_in = 16'h0000, d_in = 16'h0000;
	logic [7:0]  flags_out, e;
	logic        bit_write_out, dest_bit_out, done_out, illegal_out;
	int          errors = 0, checked = 0;
	bit_alu DUT (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .req_in(req_in),
		.op_in(op_in), .format_in(fmt_in), .wide_in(w_in), .src_is_areg_in(sa_in),
		.dest_is_areg_in(da_in), .src_is_imm_in(im_in), .src_reg_id_in(si_in),
		.dest_reg_id_in(di_in), .bit_in(b_in), .src_in(s_in), .dest_in(d_in),
		.flags_out(flags_out), .bit_write_out(bit_write_out), .dest_bit_out(dest_bit_out),
		.done_out(done_out), .illegal_out(illegal_out));
	initial begin
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic run(input logic [1:0] op, input logic b);
		@(negedge sys_clk_in);
		op_in  = op;
		b_in   = b;
		req_in = 1'b1;
		@(negedge sys_clk_in);
		req_in = 1'b0;
		`CK("done", (op != 2'h0), done_out)
	endtask : run
	task automatic bop(input logic [1:0] op, input logic b);
		run(op, b);
		if (op == bit_alu_pkg::OP_BIT_TEST_THEN_SET) begin
			e[bit_alu_pkg::FLAG_Z] = ~b;
			e[bit_alu_pkg::FLAG_C] = b;
			`CK("bitwr", 1'b1, bit_write_out)
			`CK("bitval", 1'b1, dest_bit_out)
		end else if (op == bit_alu_pkg::OP_BIT_XOR_INTO_CARRY)
			e[bit_alu_pkg::FLAG_C] = e[bit_alu_pkg::FLAG_C] ^ b;
		`CK("flags", e, flags_out)
	endtask : bop
	// operands as the core hands them; expectation worked out from the subtraction
	task automatic cmp(input logic [1:0] f, input logic w, sa, da, im,
		input logic [3:0] si, di, input logic [15:0] s, d);
		logic [16:0] r;
		logic [15:0] sv, dv;
		logic        bad, wd;
		fmt_in = f; w_in = w; sa_in = sa; da_in = da; im_in = im;
		si_in = si; di_in = di; s_in = s; d_in = d;
		bad = (!w && sa && da) || (f == bit_alu_pkg::FMT_SHORT && (w || sa || (!im && si == di)));
		wd  = w || da;
		sv  = (f == bit_alu_pkg::FMT_QUICK) ? {{12{s[3]}}, s[3:0]} : (w ? s : {8'h00, s[7:0]});
		if (!w)
			sv[15:8] = 8'h00;
		dv  = wd ? d : {8'h00, d[7:0]};
		if (!wd) begin
			sv = {{8{sv[7]}}, sv[7:0]};
			dv = {{8{dv[7]}}, dv[7:0]};
		end
		r = {1'b0, dv} - {1'b0, sv};
		run(bit_alu_pkg::OP_COMPARE_OP, 1'b0);
		if (!bad) begin
			e[bit_alu_pkg::FLAG_C] = wd ? (dv >= sv) : (dv[7:0] >= sv[7:0]);
			e[bit_alu_pkg::FLAG_Z] = wd ? (r[15:0] == 16'h0000) : (r[7:0] == 8'h00);
			e[bit_alu_pkg::FLAG_S] = wd ? r[15] : r[7];
			e[bit_alu_pkg::FLAG_O] = wd ? (dv[15] != sv[15] && r[15] != dv[15])
				: (dv[7] != sv[7] && r[7] != dv[7]);
		end
		`CK("illegal", bad, illegal_out)
		`CK("nowrite", 1'b0, bit_write_out)
		`CK("cmpflags", e, flags_out)
	endtask : cmp
	task automatic close_out();
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		#20000;
		errors++;
		close_out();
	end
	initial begin
		repeat (6) @(negedge sys_clk_in);
		arst_n_in = 1'b1;
		e = bit_alu_pkg::FLAGS_RESET;
		`CK("rstflags", e, flags_out)
		bop(bit_alu_pkg::OP_BIT_TEST_THEN_SET, 1'b0);
		bop(bit_alu_pkg::OP_BIT_TEST_THEN_SET, 1'b1);
		bop(bit_alu_pkg::OP_BIT_XOR_INTO_CARRY, 1'b1);
		bop(bit_alu_pkg::OP_BIT_XOR_INTO_CARRY, 1'b1);
		bop(bit_alu_pkg::OP_NONE, 1'b1);
		cmp(2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h1, 16'h0001, 16'h8000);
		bop(bit_alu_pkg::OP_BIT_XOR_INTO_CARRY, 1'b1);
		cmp(2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h1, 16'h1234, 16'h1234);
		cmp(2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h1, 16'hFFFF, 16'h0001);
		cmp(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h1, 16'h0001, 16'hAB80);
		cmp(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h1, 16'h00FF, 16'h007F);
		cmp(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 4'h8, 16'h0001, 16'h0100);
		cmp(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 4'h8, 16'h00FF, 16'h8000);
		cmp(2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h8, 4'h0, 16'h1201, 16'h0001);
		cmp(2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 4'h8, 4'h9, 16'h0002, 16'h0001);
		cmp(2'h0, 1'b1, 1'b1, 1'b1, 1'b0, 4'h8, 4'h9, 16'h0001, 16'h0001);
		cmp(2'h1, 1'b1, 1'b0, 1'b0, 1'b1, 4'h0, 4'h1, 16'h0008, 16'hFFF8);
		cmp(2'h1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 4'h1, 16'h0007, 16'h0007);
		cmp(2'h1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 4'h1, 16'hFFF8, 16'h0005);
		cmp(2'h1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 4'h8, 16'h000F, 16'h0100);
		cmp(2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 4'h0, 16'h000A, 16'h000A);
		cmp(2'h2, 1'b1, 1'b0, 1'b0, 1'b1, 4'h0, 4'h1, 16'h0001, 16'h0003);
		cmp(2'h2, 1'b0, 1'b1, 1'b0, 1'b0, 4'h8, 4'h0, 16'h0001, 16'h0003);
		cmp(2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 16'h0001, 16'h0003);
		cmp(2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h1, 16'h0005, 16'h0003);
		close_out();
	end
endmodule : bit_alu_tb
